/* File: pkg/wdo_pkg.sv */
`default_nettype none
package wdo_pkg;

   // register byte offsets, decoded on haddr[7:0]
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_CMD  = 8'h04;
   localparam logic [7:0] OFS_NMIF = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   localparam logic [7:0] OFS_MASK = 8'h10;

   // command codes
   localparam logic [7:0] CMD_DISABLE = 8'hB1;
   localparam logic [7:0] CMD_CLEAR   = 8'h4E;

   // mode register layout
   localparam int MODE_EN_BIT  = 7;
   localparam int MODE_PER_HI  = 6;
   localparam int MODE_PER_LO  = 4;
   localparam int MODE_IDLE_BIT = 2;
   localparam int MODE_ACT_BIT = 1;
   localparam int MODE_W       = 8;

   // period select: code 000 is the base exponent, each step adds two
   localparam int           PER_STEP     = 2;
   localparam int           PER_CODES    = 8;
   localparam logic [2:0]   PER_MAX_CODE = 3'h5;

   // internal reset hold: 32 states of one clock each
   localparam int RST_STATES    = 32;
   localparam int CYC_PER_STATE = 1;
   localparam int RST_HOLD_CYC  = RST_STATES * CYC_PER_STATE;
   localparam int RST_CNT_W     = 6;

   // nmi source flag register and event status layout
   localparam int NMIF_WDT_BIT = 0;
   localparam int EVT_W        = 3;

   // ahb-lite constants
   localparam int         HTRANS_ACT_BIT = 1;
   localparam logic       HRESP_OKAY     = 1'b0;
   localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;

   // mode register contents; reset: enabled, period 000, idle stop, reset action
   typedef struct packed {
      logic       enable;
      logic [2:0] period;
      logic       idle_run;
      logic       action;
   } wdo_mode_t;

   localparam wdo_mode_t MODE_RST = '{enable: 1'b1, period: 3'h0, idle_run: 1'b0, action: 1'b1};

   // sticky event status, one bit per event
   typedef struct packed {
      logic guard;   // disable code refused
      logic rst;     // internal reset issued
      logic nmi;     // overflow nmi issued
   } wdo_evt_t;

   // captured address phase of a write
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
   } wdo_aph_t;

endpackage : wdo_pkg
`default_nettype wire

/* File: testbench/wdo_nmi_partner.sv */
`default_nettype none
module wdo_nmi_partner (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic overflow_nmi_request,
   input  wire logic mcu_reset_n,
   output var  int   nmi_cnt,
   output var  int   rst_cnt,
   output var  int   rst_len
);
   timeunit 1ns;
   timeprecision 1ps;
   int run_q;  // cycles of the reset hold in progress
   // nmi entry and reset controller, both plain logic
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nmi_cnt <= 0;
         rst_cnt <= 0;
         rst_len <= 0;
         run_q   <= 0;
      end else begin
         if (overflow_nmi_request) nmi_cnt <= nmi_cnt + 1;
         if (!mcu_reset_n) begin
            run_q <= run_q + 1;
         end else if (run_q != 0) begin  // hold over, keep its length
            rst_len <= run_q;
            rst_cnt <= rst_cnt + 1;
            run_q   <= 0;
         end
      end
   end
endmodule : wdo_nmi_partner
`default_nettype wire

/* File: testbench/wdo_top_properties.sv */
`default_nettype none
module wdo_top_properties
   import wdo_pkg::*;
#(
   parameter int P_EXP_LO = 15  // exponent of the shortest period
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic [31:0] hwdata,
   input wire logic        debug_mode,
   input wire logic        overflow_nmi_request,
   input wire logic        overflow_out,
   input wire logic        mcu_reset_n
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MIN_GAP = (1 << P_EXP_LO) - 1;  // no two nmi closer than this
   logic [5:0]  low_q;  // length of the current reset hold
   logic [15:0] gap_q;  // cycles since last nmi, saturates
   // helper counters, cleared with the block
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_q <= 6'h00;
         gap_q <= 16'h0000;
      end else begin
         low_q <= mcu_reset_n ? 6'h00 : low_q + 6'h01;
         gap_q <= overflow_nmi_request ? 16'h0000 : gap_q + {15'h0000, ~&gap_q};
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_NMI_PULSE: assert property (overflow_nmi_request |=> !overflow_nmi_request)
      else $error("nmi request wider than one cycle");
   AST_NMI_GAP: assert property (overflow_nmi_request |-> gap_q >= MIN_GAP)
      else $error("nmi sooner than the shortest period");
   AST_OUT_LOW: assert property (overflow_nmi_request |-> !overflow_out)
      else $error("overflow output high during nmi");
   AST_OUT_FALL: assert property ($fell(overflow_out) |-> overflow_nmi_request)
      else $error("overflow output fell without nmi");
   AST_OUT_RISE: assert property ($rose(overflow_out) |-> $past(hwdata[7:0]) == CMD_CLEAR)
      else $error("overflow output rose without clear code");
   AST_RST_HOLD: assert property ($rose(mcu_reset_n) |-> low_q == 6'h20)
      else $error("internal reset not held 32 cycles");
   AST_RST_ONLY: assert property ($fell(mcu_reset_n) |-> !overflow_nmi_request)
      else $error("reset and nmi from one overflow");
   AST_DBG_FREEZE: assert property (debug_mode && $past(debug_mode) && $past(debug_mode, 2)
      |-> !$rose(overflow_nmi_request)) else $error("nmi while frozen in debug");
   COV_NMI: cover property (overflow_nmi_request);
   COV_RST: cover property ($rose(mcu_reset_n));
   COV_CLR: cover property ($rose(overflow_out));
endmodule : wdo_top_properties
`default_nettype wire

/* File: testbench/wdo_top_tb_top.sv */
`default_nettype none
module wdo_top_tb_top
   import wdo_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PLO = 3;  // short periods keep the run brief
   logic        hclk, hresetn, clk_en, hsel, hwrite, debug_mode, idle_mode;
   logic        hreadyout, hresp, nmi_req, ovf_out, rst_n, irq;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata;
   int          err_total, cmp_count, nmi_cnt, rst_cnt, rst_len, base;

   wdo_top #(.P_EXP_LO(PLO)) dut (
      .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .debug_mode(debug_mode),
      .idle_mode(idle_mode), .overflow_nmi_request(nmi_req), .overflow_out(ovf_out),
      .mcu_reset_n(rst_n), .irq(irq));
   wdo_nmi_partner model (
      .hclk(hclk), .hresetn(hresetn), .overflow_nmi_request(nmi_req), .mcu_reset_n(rst_n),
      .nmi_cnt(nmi_cnt), .rst_cnt(rst_cnt), .rst_len(rst_len));

   always #4 hclk = ~hclk;  // 125 MHz

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s exp %h seen %h", w, exp, seen);
      end
   endtask : chk

   // one bus phase; ends at the edge where hready is seen high
   task automatic rdy(inout int n);
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
   endtask : rdy

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= w;
      rdy(n);
      htrans <= 2'h0;
      hwdata <= d;
      rdy(n);
      q = hrdata;
      if (n >= 20) begin  // slave never answered
         err_total++;
         give_verdict();
      end
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(w, q, e);
   endtask : rdc

   // skips two edges so a pulse already in flight is not counted
   task automatic watch(input string w, input int lim, input logic e);
      int c0;
      repeat (2) @(posedge hclk);
      c0 = nmi_cnt;
      repeat (lim) @(posedge hclk);
      chk(w, {31'h0, nmi_cnt != c0}, {31'h0, e});
   endtask : watch

   task automatic period(input logic [2:0] c);
      int n;
      int e;
      n = 0;
      e = 1 << (PLO + 2 * c);
      wr(OFS_MODE, {24'h0, 1'b1, c, 4'h0});
      wr(OFS_CMD, {24'h0, CMD_CLEAR});
      while (nmi_req !== 1'b1 && n < e + 9) begin
         @(posedge hclk);
         n++;
      end
      chk("period", {31'h0, n >= e - 2 && n <= e + 2}, 32'h1);
   endtask : period

   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      clk_en = 1'b1;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      debug_mode = 1'b0;
      idle_mode = 1'b0;
      err_total = 0;
      cmp_count = 0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      rdc("mode", OFS_MODE, 32'h82);
      wr(OFS_MODE, 32'h90);
      watch("first nmi", 40, 1'b1);
      chk("out low", {31'h0, ovf_out}, 32'h0);
      wr(OFS_CMD, {24'h0, CMD_CLEAR});
      @(posedge hclk);
      chk("out high", {31'h0, ovf_out}, 32'h1);
      rdc("flag kept", OFS_NMIF, 32'h1);
      rdc("flag gone", OFS_NMIF, 32'h0);
      rdc("hole", 8'h20, 32'h0);
      // reset action on overflow
      wr(OFS_MODE, 32'hA2);
      wr(OFS_CMD, {24'h0, CMD_CLEAR});
      base = rst_cnt;
      for (int i = 0; i < 200 && rst_cnt == base; i++) @(posedge hclk);
      chk("rst seen", {31'h0, rst_cnt != base}, 32'h1);
      chk("rst len", rst_len, 32'h20);
      chk("hresp", {31'h0, hresp}, 32'h0);
      rdc("status", OFS_STAT, 32'h3);
      // refused disable raises the guard event and irq
      wr(OFS_MODE, 32'hD0);
      wr(OFS_MASK, 32'h4);
      wr(OFS_CMD, {24'h0, CMD_DISABLE});
      wr(OFS_CMD, 32'h55);
      chk("irq on", {31'h0, irq}, 32'h1);
      rdc("guard", OFS_STAT, 32'h4);
      repeat (2) @(posedge hclk);
      chk("irq off", {31'h0, irq}, 32'h0);
      wr(OFS_MASK, 32'h0);
      wr(OFS_CMD, {24'h0, CMD_DISABLE});
      repeat (2) @(posedge hclk);
      chk("irq masked", {31'h0, irq}, 32'h0);
      rdc("guard 2", OFS_STAT, 32'h4);
      // guarded disable sequence
      wr(OFS_MODE, 32'h80);
      wr(OFS_CMD, {24'h0, CMD_CLEAR});
      wr(OFS_CMD, {24'h0, CMD_DISABLE});
      watch("still on", 20, 1'b1);
      wr(OFS_MODE, 32'h00);
      watch("half off", 20, 1'b1);
      wr(OFS_CMD, {24'h0, CMD_DISABLE});
      watch("off", 40, 1'b0);
      for (int c = 0; c < 6; c++) begin
         period(3'(c));
      end
      for (int c = 6; c < 8; c++) begin
         wr(OFS_MODE, {24'h0, 1'b1, 3'(c), 4'h0});
         wr(OFS_CMD, {24'h0, CMD_CLEAR});
         watch("reserved", 300, 1'b0);
      end
      // debug freezes always, idle only without idle run
      for (int k = 0; k < 4; k++) begin
         debug_mode <= (k == 0 || k == 3);
         idle_mode  <= (k == 1 || k == 2);
         wr(OFS_MODE, {24'h0, 5'h10, k > 1, 2'h0});
         wr(OFS_CMD, {24'h0, CMD_CLEAR});
         watch("freeze", 40, k == 2);
      end
      // clock enable low freezes counter and stalls the bus
      debug_mode <= 1'b0;
      idle_mode  <= 1'b0;
      clk_en     <= 1'b0;
      watch("clk_en off", 40, 1'b0);
      chk("stall", {31'h0, hreadyout}, 32'h0);
      clk_en     <= 1'b1;
      watch("clk_en on", 40, 1'b1);
      give_verdict();
   end
endmodule : wdo_top_tb_top

bind wdo_top wdo_top_properties #(.P_EXP_LO(P_EXP_LO)) u_props (
   .hclk(hclk), .hresetn(hresetn), .hwdata(hwdata), .debug_mode(debug_mode),
   .overflow_nmi_request(overflow_nmi_request), .overflow_out(overflow_out), .mcu_reset_n(mcu_reset_n));
`default_nettype wire

/* File: verilog/wdo_counter.sv */
`default_nettype none
module wdo_counter
   import wdo_pkg::*;
#(
   parameter int P_EXP_LO = 15,            // exponent of period code 000
   parameter int CNT_W    = P_EXP_LO + 10  // wide enough for code 101
) (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       clk_en,
   input  wire logic       run,
   input  wire logic       clear,
   input  wire logic [2:0] sel,
   output logic            ovf
);

   logic [CNT_W-1:0]     cnt_q;  // binary counter
   logic [PER_CODES-1:0] hit;    // terminal count reached, per code

   // one terminal compare per period code; reserved codes never hit
   for (genvar g = 0; g < PER_CODES; g++) begin : g_term
      if (g <= int'(PER_MAX_CODE)) begin : g_used
         assign hit[g] = (cnt_q == CNT_W'((64'd1 << (P_EXP_LO + PER_STEP * g)) - 64'd1));
      end else begin : g_rsvd
         assign hit[g] = 1'b0;
      end
   end

   // overflow lands exactly 2^n counted cycles after a clear
   assign ovf = run & hit[sel];

   // clear beats counting; reserved codes simply wrap
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= '0;
      end else if (clk_en) begin
         if (clear) begin
            cnt_q <= '0;
         end else if (run) begin
            cnt_q <= ovf ? '0 : cnt_q + 1'b1;
         end
      end
   end

endmodule : wdo_counter
`default_nettype wire

/* File: verilog/wdo_rst_hold.sv */
`default_nettype none
module wdo_rst_hold
   import wdo_pkg::*;
(
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic clk_en,
   input  wire logic trig,
   output logic      hold
);

   logic [RST_CNT_W-1:0] cnt_q;  // remaining reset states

   // load on trigger, count down to zero; a retrigger restarts the hold
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= '0;
      end else if (clk_en) begin
         if (trig) begin
            cnt_q <= RST_CNT_W'(RST_HOLD_CYC);
         end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

   // high for exactly the loaded count of cycles
   assign hold = (cnt_q != '0);

endmodule : wdo_rst_hold
`default_nettype wire

/* File: verilog/wdo_top.sv */
`default_nettype none
module wdo_top
   import wdo_pkg::*;
#(
   parameter int P_EXP_LO = 15  // exponent of period code 000; lower for sim
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        clk_en,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // cpu state, same clock domain
   input  wire logic        debug_mode,
   input  wire logic        idle_mode,
   // to nmi logic and reset controller
   output logic             overflow_nmi_request,
   output logic             overflow_out,
   output logic             mcu_reset_n,
   output logic             irq
);

   // ------------------------------------------------------------------
   // bus front end
   // ------------------------------------------------------------------

   wdo_aph_t    aph_q;        // pending write data phase
   logic [31:0] hrdata_q;     // read data, stands in data phase

   // a transfer is taken only while the block is not frozen
   logic addr_ph;             // valid address phase this edge
   logic rd_take;             // read address phase
   logic wr_data;             // write data phase completes this edge

   assign addr_ph = hsel & hready & htrans[HTRANS_ACT_BIT] & clk_en;
   assign rd_take = addr_ph & ~hwrite;
   assign wr_data = aph_q.wr & clk_en;

   // read decode on the address phase address
   logic rd_mode;
   logic rd_nmif;
   logic rd_stat;
   logic rd_mask;

   assign rd_mode = (haddr[7:0] == OFS_MODE);
   assign rd_nmif = (haddr[7:0] == OFS_NMIF);
   assign rd_stat = (haddr[7:0] == OFS_STAT);
   assign rd_mask = (haddr[7:0] == OFS_MASK);

   // write decode on the captured address
   logic wr_mode;
   logic wr_cmd;
   logic wr_mask;

   assign wr_mode = wr_data & (aph_q.addr == OFS_MODE);
   assign wr_cmd  = wr_data & (aph_q.addr == OFS_CMD);
   assign wr_mask = wr_data & (aph_q.addr == OFS_MASK);

   // zero wait states; a frozen block stretches the transfer instead
   assign hreadyout = clk_en;
   assign hresp     = HRESP_OKAY;
   assign hrdata    = hrdata_q;

   // capture write address phases; hsize is not checked, word only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aph_q <= '0;
      end else if (clk_en) begin
         aph_q.wr   <= addr_ph & hwrite;
         aph_q.addr <= haddr[7:0];
      end
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------

   wdo_mode_t    mode_q;      // enable, period, idle, action
   logic         disabled_q;  // watchdog stopped by disable code
   logic         nmif_q;      // watchdog nmi source flag
   wdo_evt_t     stat_q;      // sticky event status
   wdo_evt_t     mask_q;      // interrupt enables

   // command decode; anything but the two codes falls through
   logic [7:0] cmd_code;
   logic       cmd_clear;     // clear code written
   logic       cmd_dis;       // disable code written
   logic       dis_ok;        // disable accepted
   logic       dis_refused;   // disable while still enabled

   assign cmd_code    = hwdata[7:0];
   assign cmd_clear   = wr_cmd & (cmd_code == CMD_CLEAR);
   assign cmd_dis     = wr_cmd & (cmd_code == CMD_DISABLE);
   assign dis_ok      = cmd_dis & ~mode_q.enable;
   assign dis_refused = cmd_dis & mode_q.enable;

   // new mode value from the write data
   wdo_mode_t mode_wr;

   assign mode_wr.enable   = hwdata[MODE_EN_BIT];
   assign mode_wr.period   = hwdata[MODE_PER_HI:MODE_PER_LO];
   assign mode_wr.idle_run = hwdata[MODE_IDLE_BIT];
   assign mode_wr.action   = hwdata[MODE_ACT_BIT];

   // mode register: bits 3 and 0 hold nothing
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q <= MODE_RST;
      end else if (clk_en && wr_mode) begin
         mode_q <= mode_wr;
      end
   end

   // stop on an accepted disable, resume when enable is written to 1
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         disabled_q <= 1'b0;
      end else if (clk_en) begin
         if (dis_ok) begin
            disabled_q <= 1'b1;
         end else if (wr_mode && mode_wr.enable) begin
            disabled_q <= 1'b0;
         end
      end
   end

   // interrupt mask
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_q <= '0;
      end else if (clk_en && wr_mask) begin
         mask_q <= wdo_evt_t'(hwdata[EVT_W-1:0]);
      end
   end

   // ------------------------------------------------------------------
   // counter and overflow handling
   // ------------------------------------------------------------------

   // run unless disabled, in debug, or idle with idle stop selected
   logic cnt_run;
   logic cnt_clear;
   logic ovf;             // overflow pulse from the counter
   logic ovf_nmi;         // overflow with nmi action
   logic ovf_rst;         // overflow with reset action
   logic rst_hold;        // internal reset being held

   assign cnt_run   = ~disabled_q & ~debug_mode & (~idle_mode | mode_q.idle_run);
   assign cnt_clear = cmd_clear | dis_ok;
   assign ovf_nmi   = ovf & ~mode_q.action;
   assign ovf_rst   = ovf & mode_q.action;

   // binary counter with selectable terminal count
   wdo_counter #(
      .P_EXP_LO (P_EXP_LO),
      .CNT_W    (P_EXP_LO + 10)
   ) u_counter (
      .hclk    (hclk),
      .hresetn (hresetn),
      .clk_en  (clk_en),
      .run     (cnt_run),
      .clear   (cnt_clear),
      .sel     (mode_q.period),
      .ovf     (ovf)
   );

   // internal reset stretcher
   wdo_rst_hold u_rst_hold (
      .hclk    (hclk),
      .hresetn (hresetn),
      .clk_en  (clk_en),
      .trig    (ovf_rst),
      .hold    (rst_hold)
   );

   // the reset controller sees the held level; this block itself stays alive
   assign mcu_reset_n = ~rst_hold;

   logic nmi_req_q;       // one-cycle nmi request
   logic ovf_out_q;       // overflow output level, idle high

   // nmi request and overflow output change on the same edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nmi_req_q <= 1'b0;
         ovf_out_q <= 1'b1;
      end else if (clk_en) begin
         nmi_req_q <= ovf_nmi;
         if (ovf_nmi) begin
            ovf_out_q <= 1'b0;
         end else if (cmd_clear) begin
            ovf_out_q <= 1'b1;
         end
      end
   end

   assign overflow_nmi_request = nmi_req_q;
   assign overflow_out         = ovf_out_q;

   // ------------------------------------------------------------------
   // flags, status and interrupt
   // ------------------------------------------------------------------

   // a read clears; a set in the same cycle wins so no event is lost
   logic     nmif_d;
   wdo_evt_t evt;
   wdo_evt_t stat_d;

   assign nmif_d     = ovf_nmi | (nmif_q & ~(rd_take & rd_nmif));
   assign evt.nmi    = ovf_nmi;
   assign evt.rst    = ovf_rst;
   assign evt.guard  = dis_refused;
   assign stat_d     = evt | (stat_q & ~{EVT_W{rd_take & rd_stat}});

   // counter clears never touch the source flag
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nmif_q <= 1'b0;
         stat_q <= '0;
      end else if (clk_en) begin
         nmif_q <= nmif_d;
         stat_q <= stat_d;
      end
   end

   // level interrupt while any unmasked status bit is set
   logic irq_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_q <= 1'b0;
      end else if (clk_en) begin
         irq_q <= |(stat_d & mask_q);
      end
   end

   assign irq = irq_q;

   // ------------------------------------------------------------------
   // read data
   // ------------------------------------------------------------------

   // mode readback with the two spare bits as zero
   logic [31:0] mode_rd;
   logic [31:0] nmif_rd;
   logic [31:0] stat_rd;
   logic [31:0] mask_rd;
   logic [31:0] rdata_mux;

   assign mode_rd = {24'h00_0000, mode_q.enable, mode_q.period, 1'b0, mode_q.idle_run, mode_q.action, 1'b0};
   assign nmif_rd = {31'h0000_0000, nmif_q};
   assign stat_rd = {29'h0000_0000, stat_q};
   assign mask_rd = {29'h0000_0000, mask_q};

   // command register is write only; unmapped offsets read zero
   assign rdata_mux = rd_mode ? mode_rd :
                      rd_nmif ? nmif_rd :
                      rd_stat ? stat_rd :
                      rd_mask ? mask_rd : RDATA_ZERO;

   // sampled at the address edge, so a read right behind a write
   // to the same register returns the value before that write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= RDATA_ZERO;
      end else if (rd_take) begin
         hrdata_q <= rdata_mux;
      end
   end

endmodule : wdo_top
`default_nettype wire
